// *** inc/irq_prio_pkg.sv ***
// Purpose: constants for the interrupt priority and pin mode block
// Assumes: APB, 32-bit data, byte offsets four times the register index
// Notes: register indices are printed offsets; byte address = 4 * index
package irq_prio_pkg;
  localparam int ADDR_W = 12;
  // register indices
  localparam logic [7:0] IDX_DMA_CH01 = 8'hF1;
  localparam logic [7:0] IDX_DMA_CH23 = 8'hF2;
  localparam logic [7:0] IDX_DMA_CH45 = 8'hF3;
  localparam logic [7:0] IDX_DMA_CH67 = 8'hF4;
  localparam logic [7:0] IDX_SER_MODE = 8'hF5;
  localparam logic [7:0] IDX_EXT_MODE = 8'hF6;
  localparam logic [7:0] IDX_WDT_FLAG = 8'hF7;
  localparam logic [7:0] IDX_FLAG_CLR = 8'hF8;
  localparam logic [7:0] IDX_IRQ_STAT = 8'hF9;
  localparam logic [7:0] IDX_IRQ_MASK = 8'hFA;
  // reset values
  localparam logic [7:0] RST_DMA_CTRL = 8'h00;
  localparam logic [2:0] RST_SER_MODE = 3'h7;
  localparam logic [5:0] RST_EXT_MODE = 6'h00;
  // ext_irq_pin_mode field positions
  localparam int EXT0_LEVEL_BIT = 1;
  localparam int EXT0_EDGE_BIT = 2;
  // status layout: 0..7 dma, 8 watchdog, 9..12 ext pins, 13..15 serial
  localparam int NUM_SRC = 16;
  localparam int SRC_DMA0 = 0;
  localparam int SRC_WDT = 8;
  localparam int SRC_EXT0 = 9;
  localparam int SRC_SER0 = 13;
  // clear vectors for the flag clear register
  localparam logic [7:0] CLR_VEC_DMA0 = 8'h00;
  localparam logic [7:0] CLR_VEC_WDT = 8'h08;
endpackage : irq_prio_pkg

// *** hw/irq_trigger.sv ***
// Purpose: one request flag with edge or level trigger detection
// Assumes: source is synchronous to pclk
// Notes: set wins over a clear arriving in the same cycle
module irq_trigger (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic src,
  input wire logic level_mode,
  input wire logic falling,
  input wire logic clear,
  output logic flag
);
  logic src_prev;
  logic hit;

  always_comb begin
    if (level_mode) begin
      hit = src;
    end else if (falling) begin
      hit = src_prev & ~src;
    end else begin
      hit = ~src_prev & src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_prev <= 1'b0;
    end else if (clk_en) begin
      src_prev <= src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag <= 1'b0;
    end else if (clk_en) begin
      if (hit) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule : irq_trigger

// *** hw/irq_prio_ctrl.sv ***
// Purpose: per-channel dma priority, trigger modes and request flags
// Assumes: APB slave, zero wait states, inputs synchronous to pclk
// Notes: disabled sources still latch flags and can raise irq; only enabled ones are offered on dma_req_pending
//
// Contract
// - priority 000 or 111 disables; else level
// - ext0 edge rise/fall, or high level
// - ext1..3 edge only, select rise/fall
// - serial rx rising edge or level; reset 1
//
// The implementer's own choice: the APB interface to the registers.
module irq_prio_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_prio_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] dma_done_irq,
  input wire logic watchdog_irq,
  input wire logic [3:0] ext_irq_pin,
  input wire logic [2:0] serial_rx_irq,
  input wire logic [7:0] service_ack,
  output logic [7:0] dma_req_pending,
  output logic [7:0][2:0] dma_req_level,
  output logic watchdog_req_flag,
  output logic [3:0] ext_req_flag,
  output logic [2:0] serial_req_flag,
  output logic irq
);
  import irq_prio_pkg::*;

  // ==========================================================
  // bus decode
  logic [7:0][2:0] prio;
  logic [2:0] serial_rx_level_select;
  logic [5:0] ext_mode;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] status;
  logic [NUM_SRC-1:0] mask;
  logic [NUM_SRC-1:0] clr;
  logic [NUM_SRC-1:0] next_status;
  logic [7:0] idx;
  logic aligned;
  logic mapped;
  logic wr;
  logic rd;
  logic [31:0] next_rdata;

  assign idx = paddr[9:2];
  assign aligned = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign mapped = aligned && (idx >= IDX_DMA_CH01) && (idx <= IDX_IRQ_MASK);
  assign wr = psel && penable && pwrite && mapped && clk_en;
  assign rd = psel && penable && !pwrite && mapped && clk_en;
  // one-cycle access phase; frozen while clock enable is low
  assign pready = clk_en;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================
  // priority fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        prio[i] <= RST_DMA_CTRL[2:0];
      end
    end else if (wr && idx >= IDX_DMA_CH01 && idx <= IDX_DMA_CH67) begin
      prio[{idx[1:0] - 2'h1, 1'b0}] <= pwdata[2:0];
      prio[{idx[1:0] - 2'h1, 1'b1}] <= pwdata[6:4];
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      // 000 and 111 both mean the source is off
      dma_req_pending[i] = flags[SRC_DMA0 + i] && prio[i] != 3'h0
        && prio[i] != 3'h7;
      dma_req_level[i] = dma_req_pending[i] ? prio[i] : 3'h0;
    end
  end

  // ==========================================================
  // trigger mode registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_rx_level_select <= RST_SER_MODE;
    end else if (wr && idx == IDX_SER_MODE) begin
      serial_rx_level_select <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_mode <= RST_EXT_MODE;
    end else if (wr && idx == IDX_EXT_MODE) begin
      // bit 0 must be written as zero; kept clear
      ext_mode <= {pwdata[5:1], 1'b0};
    end
  end

  // ==========================================================
  // request flags
  always_comb begin
    clr = '0;
    for (int i = 0; i < 8; i++) begin
      clr[SRC_DMA0 + i] = service_ack[i];
    end
    if (wr && idx == IDX_FLAG_CLR) begin
      if (pwdata[7:0] < CLR_VEC_WDT) begin
        clr[pwdata[2:0]] = 1'b1;
      end else if (pwdata[7:0] < 8'h10) begin
        clr[pwdata[3:0]] = 1'b1;
      end
    end
  end

  irq_trigger u_dma_trig[7:0] (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .src(dma_done_irq), .level_mode(1'b0), .falling(1'b0),
    .clear(clr[SRC_DMA0 +: 8]), .flag(flags[SRC_DMA0 +: 8]));

  irq_trigger u_wdt_trig (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .src(watchdog_irq), .level_mode(1'b0), .falling(1'b0),
    .clear(clr[SRC_WDT]), .flag(flags[SRC_WDT]));

  irq_trigger u_ext0_trig (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .src(ext_irq_pin[0]), .level_mode(ext_mode[EXT0_LEVEL_BIT]),
    .falling(ext_mode[EXT0_EDGE_BIT]),
    .clear(clr[SRC_EXT0]), .flag(flags[SRC_EXT0]));

  irq_trigger u_ext_trig[2:0] (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .src(ext_irq_pin[3:1]), .level_mode(1'b0),
    .falling(ext_mode[5:3]),
    .clear(clr[SRC_EXT0+1 +: 3]), .flag(flags[SRC_EXT0+1 +: 3]));

  irq_trigger u_ser_trig[2:0] (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .src(serial_rx_irq), .level_mode(serial_rx_level_select),
    .falling(1'b0),
    .clear(clr[SRC_SER0 +: 3]), .flag(flags[SRC_SER0 +: 3]));

  assign watchdog_req_flag = flags[SRC_WDT];
  assign ext_req_flag = flags[SRC_EXT0 +: 4];
  assign serial_req_flag = flags[SRC_SER0 +: 3];

  // ==========================================================
  // sticky status, cleared by reading it; new rise wins the clear
  logic [NUM_SRC-1:0] flags_prev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_prev <= '0;
    end else if (clk_en) begin
      flags_prev <= flags;
    end
  end

  always_comb begin
    next_status = status;
    if (rd && idx == IDX_IRQ_STAT) begin
      next_status = '0;
    end
    next_status = next_status | (flags & ~flags_prev);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (clk_en) begin
      status <= next_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask <= '0;
    end else if (wr && idx == IDX_IRQ_MASK) begin
      mask <= pwdata[NUM_SRC-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (clk_en) begin
      irq <= |(next_status & mask);
    end
  end

  // ==========================================================
  // read data; write-only fields read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (idx)
      IDX_DMA_CH01, IDX_DMA_CH23, IDX_DMA_CH45, IDX_DMA_CH67: begin
        next_rdata[2:0] = prio[{idx[1:0] - 2'h1, 1'b0}];
        next_rdata[3] = flags[{idx[1:0] - 2'h1, 1'b0}];
        next_rdata[6:4] = prio[{idx[1:0] - 2'h1, 1'b1}];
        next_rdata[7] = flags[{idx[1:0] - 2'h1, 1'b1}];
      end
      IDX_EXT_MODE: next_rdata[EXT0_LEVEL_BIT] = ext_mode[EXT0_LEVEL_BIT];
      IDX_WDT_FLAG: next_rdata[3] = flags[SRC_WDT];
      IDX_IRQ_STAT: next_rdata[NUM_SRC-1:0] = status;
      IDX_IRQ_MASK: next_rdata[NUM_SRC-1:0] = mask;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite && clk_en) begin
      prdata <= next_rdata;
    end
  end

  // ==========================================================
  // checks
  a_prio_disable: assert property (@(posedge pclk) disable iff (!presetn)
    (prio[0] == 3'h7) |-> !dma_req_pending[0])
    else $error("priority 7 did not disable channel 0");
  a_prio_level: assert property (@(posedge pclk) disable iff (!presetn)
    dma_req_pending[1] |-> dma_req_level[1] == prio[1])
    else $error("channel 1 level differs from field");
  a_ext0_rise: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && !ext_mode[1] && !ext_mode[2] && $rose(ext_irq_pin[0])
    |=> flags[SRC_EXT0])
    else $error("ext0 rising edge missed");
  a_ext0_level: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ext_mode[1] && ext_irq_pin[0] |=> flags[SRC_EXT0])
    else $error("ext0 high level missed");
  a_ext1_fall: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && ext_mode[3] && $fell(ext_irq_pin[1])
    |=> flags[SRC_EXT0+1])
    else $error("ext1 falling edge missed");
  a_ser_level: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && serial_rx_level_select[0] && serial_rx_irq[0]
    |=> flags[SRC_SER0])
    else $error("serial 0 level missed");
  a_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    flags[SRC_WDT] && !clr[SRC_WDT] |=> flags[SRC_WDT])
    else $error("watchdog flag dropped without clear");
  a_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clk_en && clr[SRC_WDT] && !watchdog_irq && !flags_prev[SRC_WDT]
    |=> !flags[SRC_WDT] || watchdog_irq)
    else $error("watchdog flag not cleared");
  c_ext0_level: cover property (@(posedge pclk) flags[SRC_EXT0] && ext_mode[1]);
  c_irq_out: cover property (@(posedge pclk) $rose(irq));
  c_dma_prio6: cover property (@(posedge pclk)
    dma_req_pending[7] && dma_req_level[7] == 3'h6);
endmodule : irq_prio_ctrl

// *** tb/irq_src_model.sv ***
// Purpose: cpu side servicing model for the dma done request lines
// Assumes: pending lines are synchronous to pclk
// Notes: acks the lowest pending channel after ack_wait idle cycles
module irq_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ack_en,
  input wire logic [3:0] ack_wait,
  input wire logic [7:0] dma_req_pending,
  output logic [7:0] service_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt;
  // ==========================================
  // servicing
  // no ack while the last one lands, or the flag would be hit twice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      service_ack <= 8'h00;
    end else begin
      service_ack <= 8'h00;
      if (!ack_en || dma_req_pending == 8'h00 || service_ack != 8'h00) begin
        cnt <= 4'h0;
      end else if (cnt >= ack_wait) begin
        service_ack <= dma_req_pending & (~dma_req_pending + 8'h01);
        cnt <= 4'h0;
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : irq_src_model

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the priority and pin mode block
// Assumes: zero wait state apb, clk_en held high
// Notes: flags are checked one or more edges after each event
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_prio_pkg::*;
  logic pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0;
  logic pwrite = 0, watchdog_irq = 0, ack_en = 0, pready, pslverr, irq, err;
  logic watchdog_req_flag;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [7:0] dma_done_irq = '0, service_ack, dma_req_pending;
  logic [7:0][2:0] dma_req_level;
  logic [3:0] ext_irq_pin = '0, ext_req_flag, ack_wait = '0;
  logic [2:0] serial_rx_irq = '0, serial_req_flag;
  int failures = 0, tests_run = 0, cycles = 0, ch, sh, prio_m[8];
  logic [7:0] ridx;
  initial begin
    forever #25 pclk = ~pclk;
  end
  irq_prio_ctrl i_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dma_done_irq,
    .watchdog_irq, .ext_irq_pin, .serial_rx_irq, .service_ack,
    .dma_req_pending, .dma_req_level, .watchdog_req_flag, .ext_req_flag,
    .serial_req_flag, .irq);
  irq_src_model i_model (.pclk, .presetn, .ack_en, .ack_wait,
    .dma_req_pending, .service_ack);
  // ==========================================
  // run control
  task finish_test;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      finish_test();
    end
  end
  // ==========================================
  // bus tasks
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick
  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [31:0] wd);
    apb(1, idx, wd);
  endtask : wr
  task rdc(input logic [7:0] idx, input logic [31:0] exp);
    apb(0, idx, 32'h0);
    `CHK(rd, exp)
  endtask : rdc
  // ==========================================
  // scenarios
  initial begin
    void'($urandom(32'hA29391A1));
    tick(3);
    presetn <= 1;
    for (int i = 0; i < 4; i++) begin
      rdc(8'(IDX_DMA_CH01 + i), 32'h0);
    end
    rdc(IDX_EXT_MODE, 32'h0);
    for (int s = 0; s < 3; s++) begin
      serial_rx_irq[s] <= 1;
      tick(3);
      `CHK(serial_req_flag[s], 1'b1)
      wr(IDX_FLAG_CLR, 32'(SRC_SER0 + s));
      tick(3);
      `CHK(serial_req_flag[s], 1'b1)
      wr(IDX_SER_MODE, 32'(3'h7 & ~(3'h1 << s)));
      wr(IDX_FLAG_CLR, 32'(SRC_SER0 + s));
      tick(3);
      `CHK(serial_req_flag[s], 1'b0)
      serial_rx_irq[s] <= 0;
      tick(2);
      serial_rx_irq[s] <= 1;
      tick(3);
      `CHK(serial_req_flag[s], 1'b1)
      serial_rx_irq[s] <= 0;
      wr(IDX_SER_MODE, 32'h7);
      wr(IDX_FLAG_CLR, 32'(SRC_SER0 + s));
    end
    for (int p = 0; p < 4; p++) begin
      for (int e = 0; e < 2; e++) begin
        wr(IDX_EXT_MODE, 32'(e << (2 + p)));
        wr(IDX_FLAG_CLR, 32'(SRC_EXT0 + p));
        ext_irq_pin[p] <= 1;
        tick(3);
        `CHK(ext_req_flag[p], (e == 0))
        wr(IDX_FLAG_CLR, 32'(SRC_EXT0 + p));
        ext_irq_pin[p] <= 0;
        tick(3);
        `CHK(ext_req_flag[p], (e == 1))
        wr(IDX_FLAG_CLR, 32'(SRC_EXT0 + p));
      end
    end
    wr(IDX_EXT_MODE, 32'(1 << EXT0_LEVEL_BIT));
    rdc(IDX_EXT_MODE, 32'h2);
    ext_irq_pin[0] <= 1;
    wr(IDX_FLAG_CLR, 32'(SRC_EXT0));
    tick(3);
    `CHK(ext_req_flag[0], 1'b1)
    ext_irq_pin[0] <= 0;
    wr(IDX_FLAG_CLR, 32'(SRC_EXT0));
    tick(3);
    `CHK(ext_req_flag[0], 1'b0)
    // request masked off before leaving level sensing
    wr(IDX_IRQ_MASK, 32'h0);
    wr(IDX_EXT_MODE, 32'h0);
    for (int m = 1; m >= 0; m--) begin
      wr(IDX_IRQ_MASK, 32'(m << SRC_WDT));
      apb(0, IDX_IRQ_STAT, 32'h0);
      watchdog_irq <= 1;
      tick(1);
      watchdog_irq <= 0;
      tick(4);
      `CHK(watchdog_req_flag, 1'b1)
      `CHK(irq, 1'(m))
      wr(IDX_WDT_FLAG, 32'h0);
      rdc(IDX_WDT_FLAG, 32'h8);
      rdc(IDX_IRQ_STAT, 32'(1 << SRC_WDT));
      rdc(IDX_IRQ_STAT, 32'h0);
      tick(2);
      `CHK(irq, 1'b0)
      wr(IDX_FLAG_CLR, 32'(CLR_VEC_WDT));
      tick(2);
      `CHK(watchdog_req_flag, 1'b0)
    end
    ch = $urandom % 8;
    sh = (ch % 2) * 4;
    ridx = 8'(IDX_DMA_CH01 + ch / 2);
    dma_done_irq[ch] <= 1;
    tick(1);
    dma_done_irq[ch] <= 0;
    for (int v = 0; v < 8; v++) begin
      prio_m[ch] = v;
      wr(ridx, 32'(v << sh));
      tick(1);
      `CHK(dma_req_pending[ch], (prio_m[ch] >= 1 && prio_m[ch] <= 6))
      `CHK(dma_req_level[ch], (v >= 1 && v <= 6) ? 3'(v) : 3'h0)
      rdc(ridx, 32'((v | 8) << sh));
    end
    wr(ridx, 32'(3 << sh));
    for (int w = 0; w < 2; w++) begin
      dma_done_irq[ch] <= 1;
      tick(1);
      dma_done_irq[ch] <= 0;
      tick(3);
      `CHK(dma_req_level[ch], 3'h3)
      ack_wait <= 4'(w * 5);
      ack_en <= 1;
      tick(12);
      `CHK(dma_req_pending[ch], 1'b0)
      ack_en <= 0;
    end
    apb(0, 8'h10, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    apb(1, 8'h10, 32'h5);
    `CHK(err, 1'b1)
    finish_test();
  end
endmodule : testbench
